// ===== rtl/srap_pkg.sv
// What this block does
// - A transaction opens with an instruction byte naming register and 8 or 16 bits
// - Chip select goes low first; eight active edges latch the instruction bits
// - The edge-select pin chooses rising or falling serial clock as active edge
// - Chip select stays low all transaction; raising it resets the serial logic
// - Setting convert bit starts conversion on second divided clock fall after write
// - Both bytes of a 16-bit write commit to their registers together
// - Second byte address is address plus one if even, minus one if odd
// - Read data drive begins on the non-active edge after the instruction
// - Read data bits change only on non-active serial clock edges
// - Two-wire mode releases the shared pin after the last read data edge
// - Output pin floats only while chip select is high; both pins float then
// - After a read the port expects a new instruction byte
// - Each read byte's first bit is sent live; its other bits come from a snapshot taken at its first active edge
// - Operation does not depend on the serial clock idle level
// - Mux setting comes from start-conversion instruction low bits or register 4
// - Mux bit 3 picks differential (0) or single-ended (1)
// - In differential mode mux bit 2 swaps plus and minus lines
// - Single-ended: bits 2..0 pick one of eight lines against ground
// - Registers are eight bits wide and clear to zero on reset
// - Instruction: bit7 conversion start, bit6 read, bit5 16-bit, bits 4..0 address
// - An 8-bit write instruction to register 0 clears the six writable registers at once, then waits for a sync one
package srap_pkg;
    localparam logic [4:0] ADDR_ADC_LO     = 5'h00;
    localparam logic [4:0] ADDR_ADC_HI     = 5'h01;
    localparam logic [4:0] ADDR_PGA_VALID  = 5'h02;
    localparam logic [4:0] ADDR_AD_CTL     = 5'h03;
    localparam logic [4:0] ADDR_GAIN_MUX   = 5'h04;
    localparam logic [4:0] ADDR_DIO_STATE  = 5'h05;
    localparam logic [4:0] ADDR_DIO_CTL    = 5'h06;
    localparam logic [4:0] ADDR_REF_OSC    = 5'h07;
    localparam logic [4:0] ADDR_SI_CTL     = 5'h18;
    localparam logic [4:0] ADDR_ID         = 5'h1f;
    localparam int         INSTR_MODE_BIT  = 7;
    localparam int         INSTR_READ_BIT  = 6;
    localparam int         INSTR_LEN16_BIT = 5;
    localparam int         CONVERT_BUSY_BIT = 7;
    localparam int         SI_LSB_HI_BIT   = 7;
    localparam int         SI_LSB_LO_BIT   = 0;
    localparam int         SI_2W_HI_BIT    = 6;
    localparam int         SI_2W_LO_BIT    = 1;
    localparam logic [7:0] REG_RESET       = 8'h00;
    localparam logic [3:0] LAST_BIT_8      = 4'h7;
    localparam logic [3:0] LAST_BIT_16     = 4'hf;
    localparam logic [1:0] CONV_FALL_LAST  = 2'h1;
    // Arbitrary identification value
    localparam logic [7:0] ID_VALUE        = 8'h5a;

    typedef enum logic [2:0] {
        PH_INSTR = 3'b000,
        PH_WRITE = 3'b001,
        PH_READ  = 3'b010,
        PH_RTAIL = 3'b011,
        PH_SYNC  = 3'b100
    } srap_phase_e;
endpackage : srap_pkg

// ===== rtl/srap_port.sv
`timescale 1ns/1ps
module srap_port
    import srap_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       rst,
    input  wire logic       sclk,
    input  wire logic       cs_n,
    input  wire logic       sdi_in,
    input  wire logic       edge_rise_sel,
    input  wire logic       divided_conversion_clock,
    input  wire logic       conversion_done,
    input  wire logic [7:0] adc_lo_byte,
    input  wire logic [7:0] adc_hi_byte,
    input  wire logic [7:0] pga_valid_byte,
    output logic            sdo_out,
    output logic            sdo_oe,
    output logic            sdi_out,
    output logic            sdi_oe,
    output logic [7:0]      ad_control,
    output logic [7:0]      gain_mux,
    output logic [7:0]      dio_state,
    output logic [7:0]      dio_control,
    output logic [7:0]      ref_osc_control,
    output logic [7:0]      serial_if_control,
    output logic            conversion_start,
    output logic [2:0]      plus_line,
    output logic [2:0]      minus_line,
    output logic            minus_is_ground
);
    typedef struct packed {
        logic [1:0]  sclk_s;
        logic [1:0]  cs_s;
        logic [1:0]  din_s;
        logic [1:0]  esel_s;
        logic [1:0]  divided_conversion_clock_s;
        logic        sclk_d;
        logic        divided_conversion_clock_d;
        srap_phase_e phase;
        logic [3:0]  cnt;
        logic [7:0]  instr;
        logic [15:0] wdata;
        logic [7:0]  snap;
        logic        sdo;
        logic        sdo_oe;
        logic        sdi_oe;
        logic [7:0]  ad_ctl;
        logic [7:0]  gain_mux;
        logic [7:0]  dio_state;
        logic [7:0]  dio_ctl;
        logic [7:0]  ref_osc;
        logic [7:0]  si_ctl;
        logic        conv_armed;
        logic [1:0]  conv_falls;
        logic        conv_start;
        logic [3:0]  conv_mux;
        logic [2:0]  plus_line;
        logic [2:0]  minus_line;
        logic        minus_gnd;
    } srap_state_s;

    srap_state_s cur;
    srap_state_s next_cur;

    logic        cs_active;
    logic        sclk_rise;
    logic        sclk_fall;
    logic        act_edge;
    logic        nonact_edge;
    logic        divided_conversion_clock_fall;
    logic        din;
    logic        lsb_first;
    logic        two_wire;
    logic        len16;
    logic [4:0]  addr;
    logic [4:0]  cur_addr;
    logic [3:0]  last_bit;
    logic [7:0]  live_byte;
    logic [7:0]  new_instr;

    function automatic logic [4:0] pair_addr(input logic [4:0] a);
        pair_addr = a[0] ? (a - 5'h01) : (a + 5'h01);
    endfunction : pair_addr

    function automatic logic [2:0] bit_slot(input logic [2:0] pos, input logic lsb);
        bit_slot = lsb ? pos : (3'h7 - pos);
    endfunction : bit_slot

    function automatic logic [7:0] read_reg(input logic [4:0] a, input srap_state_s s);
        case (a)
            ADDR_ADC_LO:    read_reg = adc_lo_byte;
            ADDR_ADC_HI:    read_reg = adc_hi_byte;
            ADDR_PGA_VALID: read_reg = pga_valid_byte;
            ADDR_AD_CTL:    read_reg = s.ad_ctl;
            ADDR_GAIN_MUX:  read_reg = s.gain_mux;
            ADDR_DIO_STATE: read_reg = s.dio_state;
            ADDR_DIO_CTL:   read_reg = s.dio_ctl;
            ADDR_REF_OSC:   read_reg = s.ref_osc;
            ADDR_SI_CTL:    read_reg = s.si_ctl;
            ADDR_ID:        read_reg = ID_VALUE;
            default:        read_reg = 8'h00;
        endcase
    endfunction : read_reg

    function automatic srap_state_s write_reg(input srap_state_s s, input logic [4:0] a,
                                               input logic [7:0] d);
        srap_state_s r;
        r = s;
        case (a)
            ADDR_AD_CTL:    r.ad_ctl = d;
            ADDR_GAIN_MUX:  r.gain_mux = d;
            ADDR_DIO_STATE: r.dio_state = d;
            ADDR_DIO_CTL:   r.dio_ctl = d;
            ADDR_REF_OSC:   r.ref_osc = d;
            ADDR_SI_CTL:    r.si_ctl = d;
            default:        r.si_ctl = s.si_ctl;
        endcase
        write_reg = r;
    endfunction : write_reg

    // Decode of a mux code into the lines feeding the amplifier inputs
    function automatic srap_state_s start_conv(input srap_state_s s, input logic [3:0] m);
        srap_state_s r;
        r = s;
        r.conv_start = 1'b1;
        r.conv_mux = m;
        if (m[3]) begin
            r.plus_line = m[2:0];
            r.minus_line = 3'h0;
            r.minus_gnd = 1'b1;
        end else begin
            r.plus_line = {m[1:0], m[2]};
            r.minus_line = {m[1:0], ~m[2]};
            r.minus_gnd = 1'b0;
        end
        start_conv = r;
    endfunction : start_conv

    // Edges come from synchronised copies only; the idle level never matters
    assign cs_active   = ~cur.cs_s[1];
    assign din         = cur.din_s[1];
    assign sclk_rise   = cur.sclk_s[1] & ~cur.sclk_d;
    assign sclk_fall   = ~cur.sclk_s[1] & cur.sclk_d;
    assign act_edge    = cur.esel_s[1] ? sclk_rise : sclk_fall;
    assign nonact_edge = cur.esel_s[1] ? sclk_fall : sclk_rise;
    assign divided_conversion_clock_fall   = cur.divided_conversion_clock_d & ~cur.divided_conversion_clock_s[1];
    assign lsb_first   = cur.si_ctl[SI_LSB_HI_BIT] | cur.si_ctl[SI_LSB_LO_BIT];
    assign two_wire    = cur.si_ctl[SI_2W_HI_BIT] | cur.si_ctl[SI_2W_LO_BIT];
    assign len16       = cur.instr[INSTR_LEN16_BIT];
    assign addr        = cur.instr[4:0];
    assign cur_addr    = cur.cnt[3] ? pair_addr(addr) : addr;
    assign last_bit    = len16 ? LAST_BIT_16 : LAST_BIT_8;
    assign live_byte   = read_reg(cur_addr, cur);
    assign new_instr   = {cur.instr[6:0], din};

    always_comb begin
        next_cur = cur;
        next_cur.sclk_s = {cur.sclk_s[0], sclk};
        next_cur.cs_s   = {cur.cs_s[0], cs_n};
        next_cur.din_s  = {cur.din_s[0], sdi_in};
        next_cur.esel_s = {cur.esel_s[0], edge_rise_sel};
        next_cur.divided_conversion_clock_s = {cur.divided_conversion_clock_s[0], divided_conversion_clock};
        next_cur.sclk_d = cur.sclk_s[1];
        next_cur.divided_conversion_clock_d = cur.divided_conversion_clock_s[1];
        next_cur.conv_start = 1'b0;

        if (conversion_done) begin
            next_cur.gain_mux[CONVERT_BUSY_BIT] = 1'b0;
            next_cur.dio_state[CONVERT_BUSY_BIT] = 1'b0;
        end
        if (cur.conv_armed && divided_conversion_clock_fall) begin
            next_cur.conv_falls = cur.conv_falls + 2'h1;
            if (cur.conv_falls == CONV_FALL_LAST) begin
                next_cur.conv_armed = 1'b0;
                next_cur = start_conv(next_cur, cur.conv_mux);
            end
        end

        if (!cs_active) begin
            next_cur.phase = PH_INSTR;
            next_cur.cnt = 4'h0;
            next_cur.sdo_oe = 1'b0;
            next_cur.sdi_oe = 1'b0;
        end else begin
            next_cur.sdo_oe = 1'b1;
            case (cur.phase)
                PH_INSTR: begin
                    if (act_edge) begin
                        next_cur.instr = new_instr;
                        next_cur.cnt = cur.cnt + 4'h1;
                        if (cur.cnt == LAST_BIT_8) begin
                            next_cur.cnt = 4'h0;
                            if (new_instr[INSTR_MODE_BIT]) begin
                                next_cur = start_conv(next_cur, new_instr[3:0]);
                            end else if (new_instr[INSTR_READ_BIT]) begin
                                next_cur.phase = PH_READ;
                            end else if (!new_instr[INSTR_LEN16_BIT] &&
                                         new_instr[4:0] == ADDR_ADC_LO) begin
                                // The six writable registers and any armed start clear, then waits for a sync one on data
                                next_cur.ad_ctl = REG_RESET;
                                next_cur.gain_mux = REG_RESET;
                                next_cur.dio_state = REG_RESET;
                                next_cur.dio_ctl = REG_RESET;
                                next_cur.ref_osc = REG_RESET;
                                next_cur.si_ctl = REG_RESET;
                                next_cur.conv_armed = 1'b0;
                                next_cur.phase = PH_SYNC;
                            end else begin
                                next_cur.phase = PH_WRITE;
                            end
                        end
                    end
                end
                PH_WRITE: begin
                    if (act_edge) begin
                        next_cur.wdata[{cur.cnt[3], bit_slot(cur.cnt[2:0], lsb_first)}] = din;
                        next_cur.cnt = cur.cnt + 4'h1;
                        if (cur.cnt == last_bit) begin
                            // One cycle commits both bytes together
                            next_cur = write_reg(next_cur, addr, next_cur.wdata[7:0]);
                            if (len16) begin
                                next_cur = write_reg(next_cur, pair_addr(addr),
                                                     next_cur.wdata[15:8]);
                            end
                            if (next_cur.gain_mux[CONVERT_BUSY_BIT] &&
                                !cur.gain_mux[CONVERT_BUSY_BIT] ||
                                next_cur.dio_state[CONVERT_BUSY_BIT] &&
                                !cur.dio_state[CONVERT_BUSY_BIT]) begin
                                next_cur.conv_armed = 1'b1;
                                next_cur.conv_falls = 2'h0;
                                next_cur.conv_mux = next_cur.gain_mux[3:0];
                            end
                            next_cur.phase = PH_INSTR;
                            next_cur.cnt = 4'h0;
                        end
                    end
                end
                PH_READ: begin
                    if (act_edge) begin
                        if (cur.cnt[2:0] == 3'h0) begin
                            next_cur.snap = live_byte;
                        end
                        next_cur.cnt = cur.cnt + 4'h1;
                        if (cur.cnt == last_bit) begin
                            next_cur.phase = PH_RTAIL;
                        end
                    end else if (nonact_edge) begin
                        // First bit of a byte goes out before its snapshot exists
                        next_cur.sdo = (cur.cnt[2:0] == 3'h0) ?
                            live_byte[bit_slot(cur.cnt[2:0], lsb_first)] :
                            cur.snap[bit_slot(cur.cnt[2:0], lsb_first)];
                        next_cur.sdi_oe = two_wire;
                    end
                end
                PH_RTAIL: begin
                    if (nonact_edge) begin
                        next_cur.sdi_oe = 1'b0;
                        next_cur.phase = PH_INSTR;
                        next_cur.cnt = 4'h0;
                    end
                end
                PH_SYNC: begin
                    // Stays here until a one arrives, so the next bit opens a fresh instruction
                    if (act_edge && din) begin
                        next_cur.phase = PH_INSTR;
                        next_cur.cnt = 4'h0;
                    end
                end
                default: begin
                    next_cur.phase = PH_INSTR;
                    next_cur.cnt = 4'h0;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cur <= '0;
            cur.cs_s <= 2'h3;
        end else begin
            cur <= next_cur;
        end
    end

    assign sdo_out           = cur.sdo;
    assign sdo_oe            = cur.sdo_oe;
    // One bit register feeds both pins; only the enables tell them apart
    assign sdi_out           = cur.sdo;
    assign sdi_oe            = cur.sdi_oe;
    assign ad_control        = cur.ad_ctl;
    assign gain_mux          = cur.gain_mux;
    assign dio_state         = cur.dio_state;
    assign dio_control       = cur.dio_ctl;
    assign ref_osc_control   = cur.ref_osc;
    assign serial_if_control = cur.si_ctl;
    assign conversion_start  = cur.conv_start;
    assign plus_line         = cur.plus_line;
    assign minus_line        = cur.minus_line;
    assign minus_is_ground   = cur.minus_gnd;
endmodule : srap_port

// ===== verif/serial_register_access_port_test.sv
`timescale 1ns/1ps
module serial_register_access_port_test;
    localparam int LIMIT = 30000;
    logic        core_clk = 1'b0;
    logic        rst = 1'b1;
    logic        edge_rise_sel;
    logic        divided_conversion_clock;
    logic        conversion_done;
    logic [7:0]  pga_valid_byte;
    logic [7:0]  adc_lo_byte;
    logic [7:0]  adc_hi_byte;
    wire         sclk, cs_n, sdi_in, sdo_out, sdo_oe, sdi_out, sdi_oe;
    wire         conversion_start, minus_is_ground;
    wire  [7:0]  ad_control, gain_mux, dio_state, dio_control, ref_osc_control, serial_if_control;
    wire  [2:0]  plus_line, minus_line;
    int          err_count = 0;
    int          n_tests = 0;
    int          n_conv = 0;
    int          cycles = 0;
    int          c0;
    logic [15:0] q;
    logic [15:0] rx;
    logic [7:0]  v;
    logic [3:0]  m;

    always #12.5 core_clk = ~core_clk;

    srap_port uut (
        .core_clk(core_clk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .sdi_in(sdi_in),
        .edge_rise_sel(edge_rise_sel), .divided_conversion_clock(divided_conversion_clock),
        .conversion_done(conversion_done), .adc_lo_byte(adc_lo_byte), .adc_hi_byte(adc_hi_byte),
        .pga_valid_byte(pga_valid_byte), .sdo_out(sdo_out), .sdo_oe(sdo_oe), .sdi_out(sdi_out),
        .sdi_oe(sdi_oe), .ad_control(ad_control), .gain_mux(gain_mux), .dio_state(dio_state),
        .dio_control(dio_control), .ref_osc_control(ref_osc_control),
        .serial_if_control(serial_if_control), .conversion_start(conversion_start),
        .plus_line(plus_line), .minus_line(minus_line), .minus_is_ground(minus_is_ground)
    );
    srap_host h (
        .core_clk(core_clk), .act_rise(edge_rise_sel), .dev_oe(sdi_oe), .dev_bit(sdi_out),
        .sdo_out(sdo_out), .sclk(sclk), .cs_n(cs_n), .sdi_line(sdi_in)
    );

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : end_of_test

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic wr(input logic [7:0] ins, input logic [15:0] d, input int n);
        h.frame_start();
        h.xfer({8'h00, ins}, 8, 1'b1, 1'b0, rx);
        if (n > 0) h.xfer(d, n, 1'b1, 1'b0, rx);
        h.frame_end();
    endtask : wr

    task automatic rd(input logic [7:0] ins, input int n, output logic [15:0] d);
        h.frame_start();
        h.xfer({8'h00, ins}, 8, 1'b1, 1'b0, rx);
        h.xfer(16'h0000, n, 1'b0, 1'b0, d);
        h.frame_end();
    endtask : rd

    task automatic fall_divided_conversion_clock();
        divided_conversion_clock = 1'b0;
        h.wait_n(6);
        divided_conversion_clock = 1'b1;
        h.wait_n(8);
    endtask : fall_divided_conversion_clock

    always @(posedge core_clk) begin
        cycles++;
        if (conversion_start === 1'b1) n_conv++;
        if (cycles == LIMIT) begin
            err_count++;
            end_of_test();
        end
    end

    initial begin
        edge_rise_sel = 1'b1;
        divided_conversion_clock = 1'b1;
        conversion_done = 1'b0;
        pga_valid_byte = 8'h2b;
        adc_lo_byte = 8'h5c;
        adc_hi_byte = 8'h3e;
        h.wait_n(2);
        rst = 1'b0;
        h.wait_n(4);
        check("reset regs", 16'h0000, {ad_control, gain_mux | dio_state | dio_control |
              ref_osc_control | serial_if_control});
        check("idle enables", 16'h0000, {14'h0000, sdo_oe, sdi_oe});
        $display("test reset done");
        for (int s = 1; s >= 0; s--) begin
            edge_rise_sel = s[0];
            // The host reads the edge choice through a port; let it settle first
            h.wait_n(1);
            v = s[0] ? 8'h25 : 8'h1a;
            h.frame_start();
            h.xfer(16'h000f, 4, 1'b1, 1'b0, rx);
            h.frame_end();
            wr(8'h03, {8'h00, v}, 8);
            check("8-bit write", {8'h00, v}, {8'h00, ad_control});
            rd(8'h43, 8, q);
            check("8-bit read", {8'h00, v}, q);
            $display("test edge select %0d done", s);
        end
        wr(8'h26, 16'h0a3c, 16);
        check("pair write", 16'h0a3c, {dio_control, ref_osc_control});
        rd(8'h67, 16, q);
        check("odd pair read", 16'h3c0a, q);
        rd(8'h60, 16, q);
        check("even pair read", 16'h5c3e, q);
        fork
            rd(8'h42, 8, q);
            begin
                h.wait_n(125);
                pga_valid_byte = 8'h55;
            end
        join
        check("snapshot read", 16'h002b, q);
        $display("test pairing done");
        wr(8'h18, 16'h0002, 8);
        h.frame_start();
        h.xfer(16'h0046, 8, 1'b1, 1'b0, rx);
        h.xfer(16'h0000, 8, 1'b0, 1'b1, q);
        h.xfer(16'h0003, 8, 1'b1, 1'b0, rx);
        h.xfer(16'h0011, 8, 1'b1, 1'b0, rx);
        h.frame_end();
        check("two-wire read", 16'h000a, q);
        check("write after read", 16'h0011, {8'h00, ad_control});
        wr(8'h18, 16'h0080, 8);
        wr(8'h03, 16'h000d, 8);
        check("lsb-first write", 16'h00b0, {8'h00, ad_control});
        rd(8'h43, 8, q);
        check("lsb-first read", 16'h000d, q);
        wr(8'h18, 16'h0000, 8);
        $display("test two-wire done");
        wr(8'h04, 16'h008b, 8);
        c0 = n_conv;
        fall_divided_conversion_clock();
        check("start after one fall", 16'(c0), 16'(n_conv));
        fall_divided_conversion_clock();
        check("start after two falls", 16'(c0 + 1), 16'(n_conv));
        check("mux from register", 16'h0031,
              {9'h000, plus_line, minus_line, minus_is_ground});
        conversion_done = 1'b1;
        h.wait_n(1);
        conversion_done = 1'b0;
        for (int i = 0; i < 16; i++) begin
            m = i[3:0];
            c0 = n_conv;
            wr({4'h8, m}, 16'h0000, 0);
            check("instruction start", 16'(c0 + 1), 16'(n_conv));
            check("mux decode", m[3] ? {9'h000, m[2:0], 3'h0, 1'b1} :
                  {9'h000, m[1:0], m[2], m[1:0], ~m[2], 1'b0},
                  {9'h000, plus_line, minus_line, minus_is_ground});
        end
        $display("test conversion done");
        wr(8'h00, 16'h0000, 0);
        check("soft reset", 16'h0000, {ad_control, dio_control | ref_osc_control | gain_mux});
        $display("test soft reset done");
        end_of_test();
    end
endmodule : serial_register_access_port_test

// ===== verif/srap_host.sv
`timescale 1ns/1ps
module srap_host (
    input  wire logic core_clk,
    input  wire logic act_rise,
    input  wire logic dev_oe,
    input  wire logic dev_bit,
    input  wire logic sdo_out,
    output logic      sclk,
    output logic      cs_n,
    output wire logic sdi_line
);
    logic host_oe = 1'b0;
    logic host_bit = 1'b0;
    logic last_bit = 1'b0;

    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
    end
    // No pull resistor, so a released line shows the inverse of its last level
    assign sdi_line = dev_oe ? dev_bit : host_oe ? host_bit : ~last_bit;
    always @(negedge core_clk) if (dev_oe || host_oe) last_bit <= sdi_line;

    task automatic wait_n(input int n);
        repeat (n) @(negedge core_clk);
    endtask : wait_n

    task automatic frame_start();
        sclk = ~act_rise; // Idle at the non-active level
        wait_n(4);
        cs_n = 1'b0;
        wait_n(6);
    endtask : frame_start

    task automatic frame_end();
        wait_n(6);
        cs_n = 1'b1; // Held low for the whole frame
        host_oe = 1'b0;
        wait_n(8);
    endtask : frame_end

    // Six core clocks a phase keeps every level above the synchroniser minimum
    task automatic xfer(input logic [15:0] tx, input int n, input logic drive,
                        input logic from_sdi, output logic [15:0] rx);
        rx = 16'h0000;
        for (int i = n - 1; i >= 0; i--) begin
            host_oe = drive;
            host_bit = tx[i];
            wait_n(6);
            sclk = act_rise;
            rx[i] = from_sdi ? sdi_line : sdo_out;
            wait_n(6);
            sclk = ~act_rise;
        end
    endtask : xfer
endmodule : srap_host

// ===== verif/srap_port_properties.sv
`timescale 1ns/1ps
module srap_port_properties (
    input wire logic       core_clk,
    input wire logic       rst,
    input wire logic       sclk,
    input wire logic       cs_n,
    input wire logic       edge_rise_sel,
    input wire logic       sdo_out,
    input wire logic       sdo_oe,
    input wire logic       sdi_oe,
    input wire logic [7:0] ad_control,
    input wire logic [7:0] gain_mux,
    input wire logic [7:0] serial_if_control,
    input wire logic       conversion_start,
    input wire logic [2:0] plus_line,
    input wire logic [2:0] minus_line,
    input wire logic       minus_is_ground
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    // Allows for the three cycles from chip select to the registered pin enables
    pins_float_a: assert property (cs_n [*4] |-> !sdo_oe && !sdi_oe)
        else $error("data pin driven while deselected");
    out_driven_a: assert property (!cs_n [*5] |-> sdo_oe)
        else $error("output pin floats while selected");
    shared_mode_a: assert property (sdi_oe |-> serial_if_control[6] || serial_if_control[1])
        else $error("shared pin driven in three-wire mode");
    bit_edge_a: assert property (
        !cs_n && $past(sdo_oe) && $changed(sdo_out) |-> sclk != edge_rise_sel)
        else $error("read bit changed near an active edge");
    write_sel_a: assert property ($changed(ad_control) |-> !$past(cs_n, 3))
        else $error("register written while deselected");
    reg_clear_a: assert property (disable iff (1'b0)
        rst |=> ad_control == 8'h00 && gain_mux == 8'h00 && serial_if_control == 8'h00)
        else $error("register not cleared by reset");
    mux_ground_a: assert property (
        conversion_start ##2 minus_is_ground |-> minus_line == 3'h0)
        else $error("single-ended minus line not grounded");
    mux_pair_a: assert property (conversion_start ##2 !minus_is_ground |->
        plus_line[2:1] == minus_line[2:1] && plus_line[0] != minus_line[0])
        else $error("differential lines not a pair");

    cover property (conversion_start);
    cover property (sdi_oe);
    cover property (conversion_start ##2 minus_is_ground);
endmodule : srap_port_properties

bind srap_port srap_port_properties u_props (
    .core_clk(core_clk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .edge_rise_sel(edge_rise_sel),
    .sdo_out(sdo_out), .sdo_oe(sdo_oe), .sdi_oe(sdi_oe), .ad_control(ad_control),
    .gain_mux(gain_mux), .serial_if_control(serial_if_control),
    .conversion_start(conversion_start), .plus_line(plus_line), .minus_line(minus_line),
    .minus_is_ground(minus_is_ground)
);
